// >>> core/sense_params.svh
`ifndef SENSE_PARAMS_SVH
`define SENSE_PARAMS_SVH
// Sense keys
`define SK_NONE          4'h0
`define SK_NOT_READY     4'h2
`define SK_MEDIUM        4'h3
`define SK_HARDWARE      4'h4
`define SK_ILLEGAL       4'h5
`define SK_UNIT_ATTN     4'h6
`define SK_ABORTED       4'hB
`define SK_MISCOMPARE    4'hE
// Additional sense codes
`define ASC_NONE         8'h00
`define ASC_NOT_READY    8'h04
`define ASC_FMT_CORRUPT  8'h31
`define ASC_DEFECT_FULL  8'h32
`define ASC_BAD_OPCODE   8'h20
`define ASC_BAD_LBA      8'h21
`define ASC_BAD_CDB_BITS 8'h24
`define ASC_BAD_LUN      8'h25
`define ASC_BAD_PARAM    8'h26
`define ASC_RESET        8'h29
`define ASC_MODE_CHG     8'h2A
`define ASC_NO_RESELECT  8'h45
`define ASC_PARITY       8'h47
`define ASC_MISCOMPARE   8'h1D
`define ASC_FIFO_UNLOAD  8'h49
`define ASC_FIFO_LOAD    8'h4A
`define ASC_FIFO_FULL    8'h4B
`define ASC_SYNC_NEG     8'h9B
// Record layout
`define REC_CODE         7'h70
`define REC_ADD_LEN      8'h0A
`define REC_UNIT_CODE    8'h00
`define REC_LEN          8'h12
`define REC_LAST         5'h11
// Byte positions
`define B_HEAD           5'h00
`define B_KEY            5'h02
`define B_INFO0          5'h03
`define B_INFO1          5'h04
`define B_INFO2          5'h05
`define B_INFO3          5'h06
`define B_ADDLEN         5'h07
`define B_ASC            5'h0C
`define B_ASCQ           5'h0D
`define B_UNIT           5'h0E
`define B_PTRFLAGS       5'h0F
`define B_PTR_HI         5'h10
`define B_PTR_LO         5'h11
// Command opcodes seen by the sense logic
`define OP_REQ_SENSE     8'h03
`define OP_INQUIRY       8'h12
`endif

// >>> core/sense_pkg.sv
// Purpose: types shared by the sense record builder
// Assumes: four initiators on the bus
// Notes:   error causes are one-hot free enum codes
package sense_pkg;
   typedef enum logic [4:0] {
      E_NOT_READY_CAL  = 5'h00,
      E_NOT_READY_SPIN = 5'h01,
      E_NOT_READY_IDLE = 5'h02,
      E_FMT_CORRUPT    = 5'h03,
      E_DEFECT_FULL    = 5'h04,
      E_NO_SPARES      = 5'h05,
      E_BAD_OPCODE     = 5'h06,
      E_BAD_LBA        = 5'h07,
      E_BAD_CDB_BITS   = 5'h08,
      E_BAD_LUN        = 5'h09,
      E_BAD_PARAM      = 5'h0A,
      E_ABORT_MSG      = 5'h0B,
      E_NO_RESELECT    = 5'h0C,
      E_PARITY         = 5'h0D,
      E_MISCOMPARE     = 5'h0E,
      E_FIFO_UNLOAD    = 5'h0F,
      E_FIFO_LOAD      = 5'h10,
      E_FIFO_FULL      = 5'h11,
      E_SYNC_NEG       = 5'h12
   } cause_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  key;
      logic [31:0] info;
      logic [7:0]  asc;
      logic [7:0]  ascq;
      logic        fp_valid;
      logic        cmd_or_data;
      logic        bp_valid;
      logic [2:0]  bit_ptr;
      logic [15:0] field_ptr;
   } sense_t;

   typedef struct packed {
      cause_t      cause;
      logic        info_valid;
      logic [31:0] lba;
      logic        fp_valid;
      logic        cmd_or_data;
      logic        bp_valid;
      logic [2:0]  bit_ptr;
      logic [15:0] field_ptr;
   } err_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SEND = 2'b01
   } phase_t;

   typedef struct packed {
      sense_t [3:0] sense;
      logic   [3:0] have;
      logic   [3:0] ua;
      logic   [3:0] ua_mode;
      phase_t       phase;
      logic   [1:0] who;
      logic   [4:0] idx;
      logic   [7:0] left;
      sense_t       cur;
      logic   [7:0] dout;
      logic         dvalid;
      logic         dlast;
      logic         chk;
      logic         exec;
      logic         done;
   } state_t;
endpackage

// >>> core/sense_builder.sv
// Purpose: per-initiator extended sense record store and sender
// Assumes: commands and errors come from the target controller on CLK
// Notes:   one byte per clock on the data-in stream; four initiators
// Notes on behaviour
// - Not ready: key 2, code 04, qualifier 00 recal, 01 spin-up, 02 idle
// - Medium: key 3; 31/00 format corrupt, 32/00 list full, 32/01 no spares
// - Bad command-block parameter gives key 5, no medium change
// - Illegal codes 20 opcode, 21 LBA, 24 bits, 25 LUN, 26 param field
// - Unit attention key 6; 29 reset, 2A mode changed by another
// - Pending attention blocks commands other than INQUIRY and REQUEST SENSE with check condition
// - Request sense returns and clears attention unless prior sense pending
// - Aborted key B; 00 abort message, 45 no reselect, 47 parity
// - Miscompare key E, code 1D qualifier 00
// - Information bytes hold the block address when valid is set
// - Additional length byte is always ten, even if truncated
// - Replaceable unit byte is zero
// - Byte 15 bit 7 flags the field pointer fields as meaningful
// - Bit 6 is one for command-block index, zero for data list
// - Bit 3 marks the three-bit bit pointer valid
// - Field pointer indexes most significant byte of faulty field
// - Buffer faults key 4; 49 unload, 4A load, 4B predicted full
// - Bad synchronous period or offset gives illegal request 9B
// - Sense kept per initiator; new command clears only its own
// - Byte 0 holds code 70 in low seven bits, valid in bit 7
// - Sense key in low nibble of byte 2, upper nibble zero
`include "sense_params.svh"
module sense_builder (
   // Clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RST,
   // Command arrival
   input  wire logic                 CMD_VALID,
   input  wire logic [1:0]           CMD_INIT,
   input  wire logic [7:0]           CMD_OPCODE,
   input  wire logic [7:0]           CMD_ALLOC,
   // Error report for the current command
   input  wire logic                 ERR_VALID,
   input  wire logic [1:0]           ERR_INIT,
   input  wire sense_pkg::err_t      ERR_INFO,
   // Unit attention events
   input  wire logic                 UA_RESET,
   input  wire logic                 UA_MODE_VALID,
   input  wire logic [1:0]           UA_MODE_INIT,
   // Data-in stream
   input  wire logic                 DIN_READY,
   output logic [7:0]                DOUT,
   output logic                      DOUT_VALID,
   output logic                      DOUT_LAST,
   // Command verdict
   output logic                      CHECK_COND,
   output logic                      EXEC_OK,
   output logic                      SENSE_DONE
);

   sense_pkg::state_t s_r;
   sense_pkg::state_t s_nxt;

   // Encode a cause into the stored record
   function automatic sense_pkg::sense_t encode(input sense_pkg::err_t e);
      sense_pkg::sense_t r;
      r = '0;
      r.valid       = e.info_valid;
      r.info        = e.lba;
      r.fp_valid    = e.fp_valid;
      r.cmd_or_data = e.cmd_or_data;
      r.bp_valid    = e.bp_valid;
      r.bit_ptr     = e.bit_ptr;
      r.field_ptr   = e.field_ptr;
      unique case (e.cause)
         sense_pkg::E_NOT_READY_CAL:  begin
            r.key = `SK_NOT_READY; r.asc = `ASC_NOT_READY; r.ascq = 8'h00;
         end
         sense_pkg::E_NOT_READY_SPIN: begin
            r.key = `SK_NOT_READY; r.asc = `ASC_NOT_READY; r.ascq = 8'h01;
         end
         sense_pkg::E_NOT_READY_IDLE: begin
            r.key = `SK_NOT_READY; r.asc = `ASC_NOT_READY; r.ascq = 8'h02;
         end
         sense_pkg::E_FMT_CORRUPT: begin
            r.key = `SK_MEDIUM; r.asc = `ASC_FMT_CORRUPT;
         end
         sense_pkg::E_DEFECT_FULL: begin
            r.key = `SK_MEDIUM; r.asc = `ASC_DEFECT_FULL;
         end
         sense_pkg::E_NO_SPARES: begin
            r.key = `SK_MEDIUM; r.asc = `ASC_DEFECT_FULL; r.ascq = 8'h01;
         end
         sense_pkg::E_BAD_OPCODE:   begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_BAD_OPCODE;
         end
         sense_pkg::E_BAD_LBA:      begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_BAD_LBA;
         end
         sense_pkg::E_BAD_CDB_BITS: begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_BAD_CDB_BITS;
         end
         sense_pkg::E_BAD_LUN:      begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_BAD_LUN;
         end
         sense_pkg::E_BAD_PARAM:    begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_BAD_PARAM;
         end
         sense_pkg::E_ABORT_MSG:    begin
            r.key = `SK_ABORTED; r.asc = `ASC_NONE;
         end
         sense_pkg::E_NO_RESELECT:  begin
            r.key = `SK_ABORTED; r.asc = `ASC_NO_RESELECT;
         end
         sense_pkg::E_PARITY:       begin
            r.key = `SK_ABORTED; r.asc = `ASC_PARITY;
         end
         sense_pkg::E_MISCOMPARE:   begin
            r.key = `SK_MISCOMPARE; r.asc = `ASC_MISCOMPARE;
         end
         sense_pkg::E_FIFO_UNLOAD:  begin
            r.key = `SK_HARDWARE; r.asc = `ASC_FIFO_UNLOAD;
         end
         sense_pkg::E_FIFO_LOAD:    begin
            r.key = `SK_HARDWARE; r.asc = `ASC_FIFO_LOAD;
         end
         sense_pkg::E_FIFO_FULL:    begin
            r.key = `SK_HARDWARE; r.asc = `ASC_FIFO_FULL;
         end
         sense_pkg::E_SYNC_NEG:     begin
            r.key = `SK_ILLEGAL; r.asc = `ASC_SYNC_NEG;
         end
         default: begin
            r.key = `SK_NONE;
         end
      endcase
      return r;
   endfunction

   // Build an attention record for one initiator
   function automatic sense_pkg::sense_t attn(input logic mode);
      sense_pkg::sense_t r;
      r = '0;
      r.key = `SK_UNIT_ATTN;
      r.asc = mode ? `ASC_MODE_CHG : `ASC_RESET;
      return r;
   endfunction

   // Select one byte of the record by position
   function automatic logic [7:0] rec_byte(input sense_pkg::sense_t r,
                                           input logic [4:0] i);
      logic [7:0] b;
      b = 8'h00;
      unique case (i)
         `B_HEAD:     b = {r.valid, `REC_CODE};
         `B_KEY:      b = {4'h0, r.key};
         `B_INFO0:    b = r.info[31:24];
         `B_INFO1:    b = r.info[23:16];
         `B_INFO2:    b = r.info[15:8];
         `B_INFO3:    b = r.info[7:0];
         `B_ADDLEN:   b = `REC_ADD_LEN;
         `B_ASC:      b = r.asc;
         `B_ASCQ:     b = r.ascq;
         `B_UNIT:     b = `REC_UNIT_CODE;
         `B_PTRFLAGS: b = {r.fp_valid, r.cmd_or_data, 2'b00,
                           r.bp_valid, r.bit_ptr};
         `B_PTR_HI:   b = r.field_ptr[15:8];
         `B_PTR_LO:   b = r.field_ptr[7:0];
         default:     b = 8'h00;
      endcase
      return b;
   endfunction

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.chk  = 1'b0;
      s_nxt.exec = 1'b0;
      s_nxt.done = 1'b0;
      // Attention events: reset marks all, mode change marks the others
      if (UA_RESET) begin
         s_nxt.ua      = 4'hF;
         s_nxt.ua_mode = 4'h0;
      end
      if (UA_MODE_VALID) begin
         for (int i = 0; i < 4; i++) begin
            if (i[1:0] != UA_MODE_INIT && !s_nxt.ua[i]) begin
               s_nxt.ua[i]      = 1'b1;
               s_nxt.ua_mode[i] = 1'b1;
            end
         end
      end
      // Command arrival while idle
      if (CMD_VALID && s_r.phase == sense_pkg::S_IDLE) begin
         if (CMD_OPCODE == `OP_REQ_SENSE) begin
            s_nxt.who = CMD_INIT;
            if (s_r.have[CMD_INIT]) begin
               s_nxt.cur = s_r.sense[CMD_INIT];
            end else if (s_r.ua[CMD_INIT]) begin
               s_nxt.cur = attn(s_r.ua_mode[CMD_INIT]);
               s_nxt.ua[CMD_INIT] = 1'b0;
            end else begin
               s_nxt.cur = '0;
            end
            s_nxt.have[CMD_INIT] = 1'b0;
            s_nxt.sense[CMD_INIT] = '0;
            s_nxt.idx  = 5'h00;
            s_nxt.left = (CMD_ALLOC < `REC_LEN) ? CMD_ALLOC : `REC_LEN;
            if (CMD_ALLOC == 8'h00) begin
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.phase = sense_pkg::S_SEND;
            end
         end else if (CMD_OPCODE == `OP_INQUIRY) begin
            s_nxt.exec = 1'b1;
         end else if (s_r.ua[CMD_INIT]) begin
            s_nxt.chk = 1'b1;
            s_nxt.sense[CMD_INIT] = attn(s_r.ua_mode[CMD_INIT]);
            s_nxt.have[CMD_INIT]  = 1'b1;
            s_nxt.ua[CMD_INIT]    = 1'b0;
         end else begin
            s_nxt.exec = 1'b1;
            s_nxt.have[CMD_INIT] = 1'b0;
            s_nxt.sense[CMD_INIT] = '0;
         end
      end
      // Error from the executing command: stored for its initiator
      if (ERR_VALID) begin
         s_nxt.sense[ERR_INIT] = encode(ERR_INFO);
         s_nxt.have[ERR_INIT]  = 1'b1;
         s_nxt.chk             = 1'b1;
      end
      // Byte stream toward the initiator
      if (s_r.phase == sense_pkg::S_SEND) begin
         if (!s_r.dvalid || DIN_READY) begin
            if (s_r.left == 8'h00) begin
               s_nxt.dvalid = 1'b0;
               s_nxt.dlast  = 1'b0;
               s_nxt.phase  = sense_pkg::S_IDLE;
               s_nxt.done   = 1'b1;
            end else begin
               s_nxt.dout   = rec_byte(s_r.cur, s_r.idx);
               s_nxt.dvalid = 1'b1;
               s_nxt.dlast  = (s_r.left == 8'h01);
               s_nxt.idx    = s_r.idx + 5'h01;
               s_nxt.left   = s_r.left - 8'h01;
            end
         end
      end
   end

   // State register
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_r <= '0;
         s_r.ua <= 4'hF;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign DOUT       = s_r.dout;
   assign DOUT_VALID = s_r.dvalid;
   assign DOUT_LAST  = s_r.dlast;
   assign CHECK_COND = s_r.chk;
   assign EXEC_OK    = s_r.exec;
   assign SENSE_DONE = s_r.done;

   // Assertions
   property p_len_byte;
      @(posedge CLK) disable iff (RST)
      (s_r.dvalid && s_r.idx == 5'h08) |-> s_r.dout == `REC_ADD_LEN;
   endproperty
   a_len_byte: assert property (p_len_byte) else $error("length byte not ten");

   property p_head;
      @(posedge CLK) disable iff (RST)
      (s_r.dvalid && s_r.idx == 5'h01) |-> s_r.dout[6:0] == `REC_CODE;
   endproperty
   a_head: assert property (p_head) else $error("bad record head");

   property p_key_nib;
      @(posedge CLK) disable iff (RST)
      (s_r.dvalid && s_r.idx == 5'h03) |-> s_r.dout[7:4] == 4'h0;
   endproperty
   a_key_nib: assert property (p_key_nib) else $error("key upper nibble set");

   property p_unit;
      @(posedge CLK) disable iff (RST)
      (s_r.dvalid && s_r.idx == 5'h0F) |-> s_r.dout == 8'h00;
   endproperty
   a_unit: assert property (p_unit) else $error("unit byte not zero");

   property p_cap;
      @(posedge CLK) disable iff (RST)
      s_r.dvalid |-> s_r.idx <= `REC_LEN;
   endproperty
   a_cap: assert property (p_cap) else $error("record overrun");

   property p_ua_block;
      @(posedge CLK) disable iff (RST)
      (CMD_VALID && s_r.phase == sense_pkg::S_IDLE && s_r.ua[CMD_INIT] && !ERR_VALID
       && CMD_OPCODE != `OP_INQUIRY && CMD_OPCODE != `OP_REQ_SENSE)
      |=> CHECK_COND && !EXEC_OK;
   endproperty
   a_ua_block: assert property (p_ua_block) else $error("attention not blocking");

   property p_inq;
      @(posedge CLK) disable iff (RST)
      (CMD_VALID && s_r.phase == sense_pkg::S_IDLE && CMD_OPCODE == `OP_INQUIRY
       && !UA_RESET && !UA_MODE_VALID) |=> EXEC_OK && $stable(s_r.ua);
   endproperty
   a_inq: assert property (p_inq) else $error("inquiry touched attention");

   property p_rs_clear;
      @(posedge CLK) disable iff (RST)
      (CMD_VALID && s_r.phase == sense_pkg::S_IDLE && CMD_OPCODE == `OP_REQ_SENSE
       && !s_r.have[CMD_INIT] && s_r.ua[CMD_INIT] && !UA_RESET && !UA_MODE_VALID)
      |=> s_r.cur.key == `SK_UNIT_ATTN && !s_r.ua[$past(CMD_INIT)];
   endproperty
   a_rs_clear: assert property (p_rs_clear) else $error("attention not returned");

endmodule

// >>> bench/initiator_sink.sv
// Purpose: data-in sink standing in for the initiator host adapter
// Assumes: one byte moves on each edge where valid and ready are both high
// Notes:   slow mode drops ready every other cycle so the sender must hold
module initiator_sink (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Bench control
   input  wire logic       slow,
   input  wire logic       clr,
   // Data-in stream
   input  wire logic [7:0] dout,
   input  wire logic       dout_valid,
   input  wire logic       dout_last,
   output logic            din_ready,
   // Captured record
   output logic [7:0]      got [0:17],
   output int              n,
   output int              last_at,
   output int              hold_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       pend;
   logic [7:0] pend_b;

   initial begin
      din_ready = 1'b1;
      hold_err = 0;
   end

   // Ready moves off the sampling edge so the sender always sees it settled
   always @(negedge clk) begin
      din_ready <= (rst || !slow) ? 1'b1 : ~din_ready;
   end

   // Bytes are kept in arrival order; a stalled byte must not change meanwhile
   always @(posedge clk) begin
      if (rst || clr) begin
         n <= 0;
         last_at <= -1;
         pend <= 1'b0;
      end else begin
         if (pend && (dout_valid !== 1'b1 || dout !== pend_b))
            hold_err <= hold_err + 1;
         pend <= (dout_valid === 1'b1) && !din_ready;
         pend_b <= dout;
         if (dout_valid === 1'b1 && din_ready) begin
            if (n < 18)
               got[n] <= dout;
            // First flagged byte only, so a flag stuck high shows up early
            if (dout_last === 1'b1 && last_at < 0)
               last_at <= n;
            n <= n + 1;
         end
      end
   end
endmodule

// >>> bench/scsi_sense_data_builder_tb.sv
// Purpose: self-checking bench for the sense record builder
// Assumes: inputs change on the falling edge, four initiators
// Notes:   attention after reset, every cause raised in turn, then attention and truncation cases
module scsi_sense_data_builder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] k;
      logic [7:0] a;
      logic [7:0] q;
   } row_t;
   logic            clk, rst, cmd_valid, err_valid, ua_reset, ua_mode_valid;
   logic            din_ready, dout_valid, dout_last, check_cond, exec_ok;
   logic            sense_done, slow, clr, saw_ok, saw_chk, saw_done;
   logic [1:0]      cmd_init, err_init, ua_mode_init;
   logic [7:0]      cmd_opcode, cmd_alloc, dout;
   logic [7:0]      got [0:17];
   sense_pkg::err_t err_info, e;
   int              n, last_at, hold_err, error_cnt, tests_run;
   row_t            rows [0:18];

   sense_builder uut (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_INIT(cmd_init),
      .CMD_OPCODE(cmd_opcode), .CMD_ALLOC(cmd_alloc), .ERR_VALID(err_valid),
      .ERR_INIT(err_init), .ERR_INFO(err_info), .UA_RESET(ua_reset),
      .UA_MODE_VALID(ua_mode_valid), .UA_MODE_INIT(ua_mode_init), .DIN_READY(din_ready),
      .DOUT(dout), .DOUT_VALID(dout_valid), .DOUT_LAST(dout_last),
      .CHECK_COND(check_cond), .EXEC_OK(exec_ok), .SENSE_DONE(sense_done));

   initiator_sink host (.clk(clk), .rst(rst), .slow(slow), .clr(clr), .dout(dout),
      .dout_valid(dout_valid), .dout_last(dout_last), .din_ready(din_ready), .got(got),
      .n(n), .last_at(last_at), .hold_err(hold_err));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One command pulse; the verdict is gathered over the two cycles after it
   task automatic cmd(input logic [1:0] who, input logic [7:0] op, input logic [7:0] al);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_init = who;
      cmd_opcode = op;
      cmd_alloc = al;
      @(negedge clk);
      cmd_valid = 1'b0;
      saw_ok = exec_ok;
      saw_chk = check_cond;
      saw_done |= sense_done;
      @(negedge clk);
      saw_ok |= exec_ok;
      saw_chk |= check_cond;
      saw_done |= sense_done;
   endtask

   task automatic raise(input logic [1:0] who, input sense_pkg::err_t x);
      @(negedge clk);
      err_valid = 1'b1;
      err_init = who;
      err_info = x;
      @(negedge clk);
      err_valid = 1'b0;
      chk(check_cond, "error without check condition");
   endtask

   // Request sense, optionally with a second command thrown in mid-transfer
   task automatic sense(input logic [1:0] who, input logic [7:0] al, input logic intrude);
      int k;
      @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      saw_done = 1'b0;
      cmd(who, 8'h03, al);
      if (intrude) begin
         cmd(2'h0, 8'h08, 8'h00);
         chk(!saw_ok && !saw_chk, "command taken during transfer");
      end
      k = 0;
      while (saw_done !== 1'b1 && k < 200) begin
         @(negedge clk);
         saw_done |= sense_done;
         k++;
      end
      chk(saw_done, "request sense never ended");
   endtask

   // Full record compare; pointer and information fields only for raised errors
   task automatic rec(input logic [3:0] k, input logic [7:0] a, q, input logic full);
      chk(got[0][6:0] === 7'h70, "record code");
      chk(got[2] === {4'h0, k}, "sense key byte");
      chk(got[7] === 8'h0A, "additional length");
      chk(got[12] === a && got[13] === q, "code or qualifier");
      chk(got[14] === 8'h00, "replaceable unit byte");
      chk(n == 18 && last_at == 17, "record length");
      if (full) begin
         chk(got[0][7] === e.info_valid, "valid flag");
         if (e.info_valid)
            chk({got[3], got[4], got[5], got[6]} === e.lba, "information");
         chk(got[15][7] === e.fp_valid, "pointer valid flag");
         if (e.fp_valid)
            chk(got[15][6] === e.cmd_or_data, "control or data");
         if (e.fp_valid)
            chk({got[16], got[17]} === e.field_ptr, "field pointer");
         if (e.fp_valid)
            chk(got[15][3] === e.bp_valid, "bit pointer flag");
         if (e.fp_valid && e.bp_valid)
            chk(got[15][2:0] === e.bit_ptr, "bit pointer");
      end
   endtask

   // Watchdog at 10000 cycles, far beyond the roughly one thousand cycles the run needs
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      {rst, cmd_valid, err_valid, ua_reset, ua_mode_valid, slow, clr} = 7'h40;
      {cmd_init, err_init, ua_mode_init, cmd_opcode, cmd_alloc} = '0;
      err_info = '0;
      e = '0;
      saw_done = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      rows = '{'{4'h2, 8'h04, 8'h00}, '{4'h2, 8'h04, 8'h01}, '{4'h2, 8'h04, 8'h02},
               '{4'h3, 8'h31, 8'h00}, '{4'h3, 8'h32, 8'h00}, '{4'h3, 8'h32, 8'h01},
               '{4'h5, 8'h20, 8'h00}, '{4'h5, 8'h21, 8'h00}, '{4'h5, 8'h24, 8'h00},
               '{4'h5, 8'h25, 8'h00}, '{4'h5, 8'h26, 8'h00}, '{4'hB, 8'h00, 8'h00},
               '{4'hB, 8'h45, 8'h00}, '{4'hB, 8'h47, 8'h00}, '{4'hE, 8'h1D, 8'h00},
               '{4'h4, 8'h49, 8'h00}, '{4'h4, 8'h4A, 8'h00}, '{4'h4, 8'h4B, 8'h00},
               '{4'h5, 8'h9B, 8'h00}};
      repeat (2) @(negedge clk);
      rst = 1'b0;
      // Attention after reset: inquiry passes, sense before any check clears it
      cmd(2'h1, 8'h12, 8'h00);
      chk(saw_ok && !saw_chk, "inquiry blocked");
      sense(2'h1, 8'h12, 1'b0);
      rec(4'h6, 8'h29, 8'h00, 1'b0);
      for (int w = 0; w < 4; w += 1 + (w == 0)) begin
         cmd(w[1:0], 8'h08, 8'h00);
         chk(!saw_ok && saw_chk, "attention not reported");
         sense(w[1:0], 8'h12, 1'b0);
         rec(4'h6, 8'h29, 8'h00, 1'b0);
      end
      cmd(2'h1, 8'h08, 8'h00);
      chk(saw_ok && !saw_chk, "cleared attention still blocks");
      // Every error cause through one initiator
      for (int i = 0; i < 19; i++) begin
         e = '0;
         e.cause = sense_pkg::cause_t'(i[4:0]);
         e.info_valid = ~i[0];
         e.lba = 32'hA5C3_0000 + 32'(i);
         e.fp_valid = (i % 3 != 0);
         e.cmd_or_data = i[1];
         e.bp_valid = i[2];
         e.bit_ptr = 3'(i + 5);
         e.field_ptr = 16'h0100 + 16'(i);
         cmd(2'h2, 8'h08, 8'h00);
         chk(saw_ok && !saw_chk, "plain command refused");
         raise(2'h2, e);
         sense(2'h2, 8'h12, 1'b0);
         rec(rows[i].k, rows[i].a, rows[i].q, 1'b1);
      end
      // A later command from the same initiator drops its stored sense
      raise(2'h2, e);
      cmd(2'h2, 8'h08, 8'h00);
      sense(2'h2, 8'h12, 1'b0);
      rec(4'h0, 8'h00, 8'h00, 1'b0);
      // Another initiator's command leaves stored sense; it outranks a new attention
      cmd(2'h3, 8'h08, 8'h00);
      raise(2'h3, e);
      cmd(2'h2, 8'h08, 8'h00);
      @(negedge clk);
      ua_reset = 1'b1;
      @(negedge clk);
      ua_reset = 1'b0;
      sense(2'h3, 8'h12, 1'b0);
      rec(4'h5, 8'h9B, 8'h00, 1'b1);
      sense(2'h3, 8'h12, 1'b0);
      rec(4'h6, 8'h29, 8'h00, 1'b0);
      // Mode change by initiator 0 reaches initiator 1 only once it is clear
      sense(2'h1, 8'h12, 1'b0);
      @(negedge clk);
      ua_mode_valid = 1'b1;
      ua_mode_init = 2'h0;
      @(negedge clk);
      ua_mode_valid = 1'b0;
      cmd(2'h1, 8'h08, 8'h00);
      chk(!saw_ok && saw_chk, "mode attention missing");
      sense(2'h1, 8'h12, 1'b0);
      rec(4'h6, 8'h2A, 8'h00, 1'b0);
      sense(2'h0, 8'h12, 1'b0);
      rec(4'h6, 8'h29, 8'h00, 1'b0);
      // Truncated, zero and over-long allocations with a stalling sink
      slow = 1'b1;
      sense(2'h2, 8'h05, 1'b0);
      chk(n == 5 && last_at == 4, "five byte transfer");
      sense(2'h2, 8'h08, 1'b0);
      chk(n == 8 && got[7] === 8'h0A, "length byte truncated");
      sense(2'h2, 8'h00, 1'b0);
      chk(n == 0, "zero allocation sent data");
      sense(2'h2, 8'hC8, 1'b1);
      chk(n == 18 && last_at == 17, "long allocation");
      chk(hold_err == 0, "stalled byte changed");
      // Reset again in mid-transfer
      cmd(2'h2, 8'h03, 8'h12);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) begin
         @(negedge clk);
         chk({dout_valid, dout_last, check_cond, exec_ok, sense_done} === 5'h00, "reset out");
      end
      rst = 1'b0;
      slow = 1'b0;
      cmd(2'h0, 8'h08, 8'h00);
      chk(!saw_ok && saw_chk, "attention lost after reset");
      sense(2'h0, 8'h12, 1'b0);
      rec(4'h6, 8'h29, 8'h00, 1'b0);
      print_verdict();
   end
endmodule
